// >>> logic/bio_pkg.sv
// Constants and types shared by the bidirectional I/O port block
package bio_pkg;
   localparam int             NUM_PORTS    = 3;
   localparam int             PORT_W       = 8;
   localparam int             NUM_LINES    = 20;
   localparam logic [7:0]     ADR_PA_DATA  = 8'h12;
   localparam logic [7:0]     ADR_PA_DIR   = 8'h13;
   localparam logic [7:0]     ADR_PB_DATA  = 8'h14;
   localparam logic [7:0]     ADR_PB_DIR   = 8'h15;
   localparam logic [7:0]     ADR_PC_DATA  = 8'h16;
   localparam logic [7:0]     ADR_PC_DIR   = 8'h17;
   localparam logic [2:0][7:0] PORT_MASK   = {8'h0f, 8'hff, 8'hff};
   localparam logic [7:0]     DATA_RST     = 8'hff;
   localparam logic [7:0]     DIR_RST      = 8'hff;
   localparam int             PA_PPG_BIT   = 0;
   localparam int             PA_PFD_BIT   = 3;
   localparam int             PA_T0_BIT    = 4;
   localparam int             PA_IRQ0_BIT  = 5;
   localparam int             PA_IRQ1_BIT  = 6;
   localparam int             PA_T1_BIT    = 7;
   localparam logic [7:0]     PC_CMP0_MASK = 8'h07;
   localparam logic [7:0]     PC_CMP1_MASK = 8'h08;

   typedef enum logic [1:0] {
      BIO_OP_SET,
      BIO_OP_CLR,
      BIO_OP_CPL,
      BIO_OP_CPLA
   } bio_op_t;
endpackage : bio_pkg

// >>> logic/bio_sync.sv
// Two-stage synchroniser for asynchronous pad inputs
module bio_sync #(
   parameter int W = 20
) (
   input  wire logic         clock,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule : bio_sync

// >>> logic/bio_pfd.sv
// Frequency divider output: toggles on each selected timer overflow
module bio_pfd (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic src_sel,
   input  wire logic ovf0,
   input  wire logic ovf1,
   output logic      freq_divider_output
);
   logic tog_ff;
   logic nxt_tog;
   logic ovf_sel;

   always_comb begin
      ovf_sel = src_sel ? ovf1 : ovf0;
      nxt_tog = tog_ff ^ ovf_sel;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tog_ff <= 1'b0;
      end else begin
         tog_ff <= nxt_tog;
      end
   end

   assign freq_divider_output = tog_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_pfd_toggle;
      ovf_sel |=> tog_ff != $past(tog_ff);
   endproperty
   a_pfd_toggle: assert property (p_pfd_toggle)
      else $error("frequency output did not toggle on overflow");

   property p_pfd_src;
      (src_sel && ovf0 && !ovf1) |=> $stable(tog_ff);
   endproperty
   a_pfd_src: assert property (p_pfd_src)
      else $error("unselected timer overflow moved the output");
endmodule : bio_pfd

// >>> logic/bio_ports.sv
// Three bidirectional I/O ports with direction, pull-high and freq output
module bio_ports (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic [2:0]       opt_pull_high,
   input  wire logic             opt_pfd_en,
   input  wire logic             opt_pfd_src,
   input  wire logic             opt_ppg_en,
   input  wire logic             mem_wr,
   input  wire logic             mem_rd,
   input  wire logic [7:0]       mem_addr,
   input  wire logic [7:0]       mem_wdata,
   output logic      [7:0]       mem_rdata,
   output logic                  mem_rvalid,
   input  wire logic             op_valid,
   input  wire bio_pkg::bio_op_t op_kind,
   input  wire logic [7:0]       op_addr,
   input  wire logic [2:0]       op_bit,
   input  wire logic             halted,
   output logic                  wake_req,
   input  wire logic             timer0_ext_input_ovf,
   input  wire logic             timer1_ext_input_ovf,
   input  wire logic             pulse_gen_one_output,
   input  wire logic             cmp0_en,
   input  wire logic             cmp1_en,
   output logic                  timer0_ext_input,
   output logic                  timer1_ext_input,
   output logic                  ext_irq_zero_n,
   output logic                  ext_irq_one_n,
   input  wire logic [7:0]       port_a_in,
   output logic      [7:0]       port_a_out,
   output logic      [7:0]       port_a_oe,
   output logic      [7:0]       port_a_pull,
   input  wire logic [7:0]       port_b_in,
   output logic      [7:0]       port_b_out,
   output logic      [7:0]       port_b_oe,
   output logic      [7:0]       port_b_pull,
   input  wire logic [3:0]       port_c_in,
   output logic      [3:0]       port_c_out,
   output logic      [3:0]       port_c_oe,
   output logic      [3:0]       port_c_pull
);
   import bio_pkg::*;

   logic [2:0][7:0] lat_ff;
   logic [2:0][7:0] nxt_lat;
   logic [2:0][7:0] dir_ff;
   logic [2:0][7:0] nxt_dir;
   logic [2:0][7:0] out_ff;
   logic [2:0][7:0] nxt_out;
   logic [2:0][7:0] oe_ff;
   logic [2:0][7:0] nxt_oe;
   logic [2:0][7:0] pull_ff;
   logic [2:0][7:0] nxt_pull;
   logic [2:0][7:0] pad_sync;
   logic [2:0][7:0] rd_port;
   logic [2:0][7:0] cmp_off;
   logic [NUM_LINES-1:0] pad_q;
   logic [7:0]      rdata_ff;
   logic [7:0]      nxt_rdata;
   logic [7:0]      pa_prev_ff;
   logic            rvalid_ff;
   logic            nxt_rvalid;
   logic            wake_ff;
   logic            nxt_wake;
   logic [2:0]      arm_ff;
   logic [2:0]      nxt_arm;
   logic [2:0]      opt_pull_ff;
   logic            opt_pfd_ff;
   logic            opt_src_ff;
   logic            opt_ppg_ff;
   logic            pfd_tog;

   function automatic logic f_hit(input logic [7:0] a);
      return (a >= ADR_PA_DATA) && (a <= ADR_PC_DIR);
   endfunction : f_hit

   function automatic logic [1:0] f_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - ADR_PA_DATA;
      return d[2:1];
   endfunction : f_idx

   // Pads cross in from the board; two stages before anything reads them
   bio_sync #(
      .W (NUM_LINES)
   ) u_sync (
      .clock   (clock),
      .sys_rst (sys_rst),
      .d       ({port_c_in, port_b_in, port_a_in}),
      .q       (pad_q)
   );
   assign pad_sync = {4'h0, pad_q};

   bio_pfd u_pfd (
      .clock               (clock),
      .sys_rst             (sys_rst),
      .src_sel             (opt_src_ff),
      .ovf0                (timer0_ext_input_ovf),
      .ovf1                (timer1_ext_input_ovf),
      .freq_divider_output (pfd_tog)
   );

   // Per-port read value and comparator pin release
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      assign rd_port[p] = ((dir_ff[p] & pad_sync[p])
                         | (~dir_ff[p] & lat_ff[p])) & PORT_MASK[p];
      if (p == 2) begin : g_cmp
         assign cmp_off[p] = ({8{cmp0_en}} & PC_CMP0_MASK)
                           | ({8{cmp1_en}} & PC_CMP1_MASK);
      end else begin : g_nocmp
         assign cmp_off[p] = 8'h00;
      end
   end

   // Register access and bit operations
   always_comb begin
      logic [1:0] p;
      logic [7:0] cur;
      p          = 2'h0;
      cur        = 8'h00;
      nxt_lat    = lat_ff;
      nxt_dir    = dir_ff;
      nxt_rdata  = 8'h00;
      nxt_rvalid = 1'b0;
      if (mem_wr && f_hit(mem_addr)) begin
         p = f_idx(mem_addr);
         if (mem_addr[0]) begin
            nxt_dir[p] = mem_wdata & PORT_MASK[p];
         end else begin
            nxt_lat[p] = mem_wdata & PORT_MASK[p];
         end
      end else if (mem_rd && f_hit(mem_addr)) begin
         p          = f_idx(mem_addr);
         nxt_rvalid = 1'b1;
         nxt_rdata  = mem_addr[0] ? dir_ff[p] : rd_port[p];
      end
      // Whole port is read first, so input bits pick up the pad level
      if (op_valid && f_hit(op_addr) && !op_addr[0]) begin
         p   = f_idx(op_addr);
         cur = rd_port[p];
         unique case (op_kind)
            BIO_OP_SET: begin
               nxt_lat[p] = (cur | (8'h01 << op_bit)) & PORT_MASK[p];
            end
            BIO_OP_CLR: begin
               nxt_lat[p] = cur & ~(8'h01 << op_bit) & PORT_MASK[p];
            end
            BIO_OP_CPL: begin
               nxt_lat[p] = ~cur & PORT_MASK[p];
            end
            BIO_OP_CPLA: begin
               nxt_rvalid = 1'b1;
               nxt_rdata  = ~cur & PORT_MASK[p];
            end
         endcase
      end
   end

   // Pad drivers: push-pull only, no open-drain mode
   always_comb begin
      nxt_oe  = ~dir_ff & PORT_MASK & ~cmp_off;
      nxt_out = lat_ff;
      if (opt_pfd_ff) begin
         nxt_out[0][PA_PFD_BIT] = lat_ff[0][PA_PFD_BIT] & pfd_tog;
      end
      // Pulse output takes the pin over; its I/O role is gone
      if (opt_ppg_ff) begin
         nxt_oe[0][PA_PPG_BIT]  = 1'b1;
         nxt_out[0][PA_PPG_BIT] = pulse_gen_one_output;
      end
      for (int i = 0; i < NUM_PORTS; i++) begin
         nxt_pull[i] = {8{opt_pull_ff[i]}} & ~nxt_oe[i]
                     & ~cmp_off[i] & PORT_MASK[i];
      end
   end

   // Wake on any change of a port A line set as input
   // Held off until the pad pipeline refills, else reset looks like an edge
   always_comb begin
      nxt_arm  = {arm_ff[1:0], 1'b1};
      nxt_wake = halted & arm_ff[2]
               & (|((pad_sync[0] ^ pa_prev_ff) & dir_ff[0]));
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         // Inputs after reset: pulled high or left floating
         lat_ff      <= {3{DATA_RST}} & PORT_MASK;
         dir_ff      <= {3{DIR_RST}} & PORT_MASK;
         out_ff      <= '0;
         oe_ff       <= '0;
         pull_ff     <= {{8{opt_pull_high[2]}}, {8{opt_pull_high[1]}},
                         {8{opt_pull_high[0]}}} & PORT_MASK;
         rdata_ff    <= 8'h00;
         rvalid_ff   <= 1'b0;
         wake_ff     <= 1'b0;
         arm_ff      <= 3'h0;
         pa_prev_ff  <= 8'h00;
         opt_pull_ff <= opt_pull_high;
         opt_pfd_ff  <= opt_pfd_en;
         opt_src_ff  <= opt_pfd_src;
         opt_ppg_ff  <= opt_ppg_en;
      end else begin
         lat_ff     <= nxt_lat;
         dir_ff     <= nxt_dir;
         out_ff     <= nxt_out;
         oe_ff      <= nxt_oe;
         pull_ff    <= nxt_pull;
         rdata_ff   <= nxt_rdata;
         rvalid_ff  <= nxt_rvalid;
         wake_ff    <= nxt_wake;
         arm_ff     <= nxt_arm;
         pa_prev_ff <= pad_sync[0];
      end
   end

   assign mem_rdata        = rdata_ff;
   assign mem_rvalid       = rvalid_ff;
   assign wake_req         = wake_ff;
   assign timer0_ext_input = pad_sync[0][PA_T0_BIT];
   assign timer1_ext_input = pad_sync[0][PA_T1_BIT];
   assign ext_irq_zero_n   = pad_sync[0][PA_IRQ0_BIT];
   assign ext_irq_one_n    = pad_sync[0][PA_IRQ1_BIT];
   assign port_a_out       = out_ff[0];
   assign port_a_oe        = oe_ff[0];
   assign port_a_pull      = pull_ff[0];
   assign port_b_out       = out_ff[1];
   assign port_b_oe        = oe_ff[1];
   assign port_b_pull      = pull_ff[1];
   assign port_c_out       = out_ff[2][3:0];
   assign port_c_oe        = oe_ff[2][3:0];
   assign port_c_pull      = pull_ff[2][3:0];

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_lat_wr;
      (mem_wr && mem_addr == ADR_PA_DATA && !op_valid)
         |=> lat_ff[0] == $past(mem_wdata);
   endproperty
   a_lat_wr: assert property (p_lat_wr)
      else $error("port A latch missed a write");

   property p_lat_hold;
      (!mem_wr && !op_valid) |=> $stable(lat_ff);
   endproperty
   a_lat_hold: assert property (p_lat_hold)
      else $error("latch changed without a write");

   property p_dir_wr;
      (mem_wr && mem_addr == ADR_PC_DIR)
         |=> dir_ff[2] == ($past(mem_wdata) & PORT_MASK[2]);
   endproperty
   a_dir_wr: assert property (p_dir_wr)
      else $error("port C direction write wrong");

   property p_rd_pad;
      (mem_rd && !mem_wr && !op_valid && mem_addr == ADR_PB_DATA
         && dir_ff[1] == 8'hff) |=> mem_rvalid
         && mem_rdata == $past(pad_sync[1]);
   endproperty
   a_rd_pad: assert property (p_rd_pad)
      else $error("input read did not return pad level");

   property p_rd_lat;
      (mem_rd && !mem_wr && !op_valid && mem_addr == ADR_PA_DATA
         && dir_ff[0] == 8'h00) |=> mem_rdata == $past(lat_ff[0]);
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("output read did not return latch");

   property p_bit_set;
      (op_valid && op_kind == BIO_OP_SET && op_addr == ADR_PB_DATA)
         |=> lat_ff[1][$past(op_bit)];
   endproperty
   a_bit_set: assert property (p_bit_set)
      else $error("bit set did not set the latch bit");

   property p_cpla;
      (op_valid && op_kind == BIO_OP_CPLA && !mem_wr)
         |=> $stable(lat_ff) && mem_rvalid;
   endproperty
   a_cpla: assert property (p_cpla)
      else $error("accumulator complement touched the latch");

   property p_oe_dir;
      ##1 port_b_oe == ~$past(dir_ff[1]);
   endproperty
   a_oe_dir: assert property (p_oe_dir)
      else $error("port B enable does not follow direction");

   property p_pfd_low;
      (opt_pfd_ff && !dir_ff[0][PA_PFD_BIT] && !lat_ff[0][PA_PFD_BIT]
         && !opt_ppg_ff) |=> port_a_oe[PA_PFD_BIT]
         && !port_a_out[PA_PFD_BIT];
   endproperty
   a_pfd_low: assert property (p_pfd_low)
      else $error("frequency pin not forced low");

   property p_wake;
      (halted && arm_ff[2]
         && ((pad_sync[0] ^ pa_prev_ff) & dir_ff[0]) != 8'h00)
         |=> wake_req;
   endproperty
   a_wake: assert property (p_wake)
      else $error("port A change did not wake");

   property p_nopull;
      !opt_pull_ff[1] |=> port_b_pull == 8'h00;
   endproperty
   a_nopull: assert property (p_nopull)
      else $error("pull enabled without option");

   c_wake: cover property (halted ##1 wake_req);
   c_pfd: cover property (opt_pfd_ff && port_a_out[PA_PFD_BIT]);
   c_cpl: cover property (op_valid && op_kind == BIO_OP_CPL);
endmodule : bio_ports

// >>> tb/bio_pads.sv
// Board-side pad model: drivers, pull-ups and floating lines
module bio_pads #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] pull,
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   output logic      [W-1:0] pad
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [W-1:0] flt = '0;
   // A floating line must not read as a stable value
   always @(posedge clock) flt <= ~flt;
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (oe[i]) pad[i] = out[i];
         else if (ext_en[i]) pad[i] = ext_val[i];
         else if (pull[i]) pad[i] = 1'b1;
         else pad[i] = flt[i];
      end
   end
endmodule : bio_pads

// >>> tb/tb.sv
// Self-checking bench for the I/O port block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bio_pkg::*;
   logic clock = 0, sys_rst = 1, opt_pfd_en = 0, opt_pfd_src = 0;
   logic [2:0] opt_pull_high = 3'h5;
   logic opt_ppg_en = 0, mem_wr = 0, mem_rd = 0, mem_rvalid, op_valid = 0;
   logic [7:0] mem_addr = 0, mem_wdata = 0, mem_rdata, op_addr = 0;
   bio_op_t op_kind = BIO_OP_SET;
   logic [2:0] op_bit = 0;
   logic halted = 0, wake_req, timer0_ext_input_ovf = 0, timer1_ext_input_ovf = 0;
   logic pulse_gen_one_output = 0, cmp0_en = 0, cmp1_en = 0;
   logic timer0_ext_input, timer1_ext_input, ext_irq_zero_n, ext_irq_one_n;
   logic [7:0] port_a_in, port_a_out, port_a_oe, port_a_pull;
   logic [7:0] port_b_in, port_b_out, port_b_oe, port_b_pull;
   logic [3:0] port_c_in, port_c_out, port_c_oe, port_c_pull;
   logic [7:0] ext_en [3] = '{8'hff, 8'hff, 8'hff};
   logic [7:0] ext_val [3];
   int err_count = 0, comparisons = 0, cyc = 0;
   int unsigned seed = 98886;

   bio_ports i_bio_ports (.clock, .sys_rst, .opt_pull_high, .opt_pfd_en,
      .opt_pfd_src, .opt_ppg_en, .mem_wr, .mem_rd, .mem_addr, .mem_wdata,
      .mem_rdata, .mem_rvalid, .op_valid, .op_kind, .op_addr, .op_bit,
      .halted, .wake_req, .timer0_ext_input_ovf, .timer1_ext_input_ovf, .pulse_gen_one_output,
      .cmp0_en, .cmp1_en, .timer0_ext_input, .timer1_ext_input,
      .ext_irq_zero_n, .ext_irq_one_n, .port_a_in, .port_a_out, .port_a_oe,
      .port_a_pull, .port_b_in, .port_b_out, .port_b_oe, .port_b_pull,
      .port_c_in, .port_c_out, .port_c_oe, .port_c_pull);
   bio_pads #(.W(8)) i_bio_pads_a (.clock, .out(port_a_out),
      .oe(port_a_oe), .pull(port_a_pull), .ext_en(ext_en[0]),
      .ext_val(ext_val[0]), .pad(port_a_in));
   bio_pads #(.W(8)) i_bio_pads_b (.clock, .out(port_b_out),
      .oe(port_b_oe), .pull(port_b_pull), .ext_en(ext_en[1]),
      .ext_val(ext_val[1]), .pad(port_b_in));
   bio_pads #(.W(4)) i_bio_pads_c (.clock, .out(port_c_out),
      .oe(port_c_oe), .pull(port_c_pull), .ext_en(ext_en[2][3:0]),
      .ext_val(ext_val[2][3:0]), .pad(port_c_in));

   always #25 clock = ~clock;

   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : xs
   function automatic logic [7:0] rd_exp(logic [7:0] dir, lat, pad);
      return (pad & dir) | (lat & ~dir);
   endfunction : rd_exp
   function automatic logic [7:0] op_exp(bio_op_t k, int b, logic [7:0] v);
      if (k == BIO_OP_SET) v[b] = 1'b1;
      else if (k == BIO_OP_CLR) v[b] = 1'b0;
      else v = ~v;
      return v;
   endfunction : op_exp
   function automatic logic [7:0] out_of(int p, bit oe);
      if (p == 0) return oe ? port_a_oe : port_a_out;
      if (p == 1) return oe ? port_b_oe : port_b_out;
      return oe ? {4'h0, port_c_oe} : {4'h0, port_c_out};
   endfunction : out_of

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask : chk1
   task automatic end_sim();
      $display("errors=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      mem_wr <= 1'b1;
      mem_addr <= a;
      mem_wdata <= d;
      @(posedge clock);
      mem_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge clock);
      mem_rd <= 1'b1;
      mem_addr <= a;
      @(posedge clock);
      mem_rd <= 1'b0;
      #1;
      d = mem_rdata;
      v = mem_rvalid;
   endtask : rd
   task automatic op(input bio_op_t k, input logic [7:0] a, input int b);
      @(posedge clock);
      op_valid <= 1'b1;
      op_kind <= k;
      op_addr <= a;
      op_bit <= 3'(b);
      @(posedge clock);
      op_valid <= 1'b0;
      #1;
   endtask : op
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_n
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
   endtask : do_reset
   task automatic ovf(input logic w);
      @(posedge clock);
      if (w) timer1_ext_input_ovf <= 1'b1;
      else timer0_ext_input_ovf <= 1'b1;
      @(posedge clock);
      timer0_ext_input_ovf <= 1'b0;
      timer1_ext_input_ovf <= 1'b0;
      wait_n(2);
   endtask : ovf
   task automatic watch(output logic s);
      s = 0;
      repeat (8) begin
         @(posedge clock);
         #1;
         if (wake_req === 1'b1) s = 1;
      end
   endtask : watch

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      logic [7:0] d, dir, lat, pad, e, m, da;
      logic v;
      int p, b;
      bio_op_t k;
      foreach (ext_val[i]) ext_val[i] = xs();
      do_reset();
      wait_n(4);
      chk8(port_a_pull, 8'hff);
      chk8(port_b_pull, 8'h00);
      chk8({port_c_pull, port_a_oe[3:0]}, 8'hf0);
      for (p = 0; p < 3; p++) begin
         m = PORT_MASK[p];
         da = ADR_PA_DATA + 8'(2 * p);
         rd(da + 8'h1, d, v);
         chk8(d, DIR_RST & m);
         rd(da, d, v);
         chk8(d, ext_val[p] & m);
      end
      wr(ADR_PA_DIR, 8'h00);
      op(BIO_OP_SET, ADR_PA_DIR, 0);
      rd(ADR_PA_DIR, d, v);
      chk8(d, 8'h00);
      rd(ADR_PA_DATA, d, v);
      chk8(d, DATA_RST);
      chk8(port_a_oe, 8'hff);
      rd(8'h11, d, v);
      chk1(v, 1'b0);
      rd(8'h18, d, v);
      chk1(v, 1'b0);
      repeat (40) begin
         p = xs() % 3;
         m = PORT_MASK[p];
         da = ADR_PA_DATA + 8'(2 * p);
         dir = xs();
         lat = xs();
         pad = xs();
         @(posedge clock);
         ext_val[p] <= pad;
         wr(da, lat);
         wr(da + 8'h1, dir);
         wait_n(3);
         chk8(out_of(p, 1), ~dir & m);
         e = rd_exp(dir, lat, pad) & m;
         rd(da, d, v);
         chk8(d, e);
         chk1(v, 1'b1);
         if (p == 0) chk8({timer1_ext_input, ext_irq_one_n, ext_irq_zero_n,
            timer0_ext_input}, {4'h0, e[7:4]});
         k = bio_op_t'(xs() % 4);
         b = (p == 2) ? xs() % 4 : xs() % 8;
         op(k, da, b);
         if (k == BIO_OP_CPLA) chk8(mem_rdata & m, ~e & m);
         else lat = op_exp(k, b, e);
         wr(da + 8'h1, 8'h00);
         wait_n(2);
         chk8(out_of(p, 0), lat & m);
         rd(da, d, v);
         chk8(d, lat & m);
      end
      // Comparator pins lose their driver and pull-up
      wr(ADR_PC_DIR, 8'h00);
      @(posedge clock);
      cmp0_en <= 1'b1;
      wait_n(2);
      chk8({port_c_oe, port_c_pull}, 8'h80);
      @(posedge clock);
      cmp0_en <= 1'b0;
      cmp1_en <= 1'b1;
      wait_n(2);
      chk8({port_c_oe, port_c_pull}, 8'h70);
      @(posedge clock);
      cmp1_en <= 1'b0;
      wr(ADR_PC_DIR, 8'hff);
      wait_n(2);
      chk8({port_c_oe, port_c_pull}, 8'h0f);
      wr(ADR_PA_DIR, 8'hff);
      @(posedge clock);
      halted <= 1'b1;
      wait_n(4);
      ext_val[0] <= ext_val[0] ^ 8'h10;
      watch(v);
      chk1(v, 1'b1);
      halted <= 1'b0;
      ext_val[0] <= ext_val[0] ^ 8'h81;
      watch(v);
      chk1(v, 1'b0);
      for (int s = 0; s < 2; s++) begin
         opt_pfd_en <= 1'b1;
         opt_pfd_src <= 1'(s);
         opt_ppg_en <= 1'(s);
         do_reset();
         // Option changes after reset must not reach the pin
         opt_pfd_en <= 1'b0;
         opt_ppg_en <= 1'b0;
         wr(ADR_PA_DATA, 8'h08);
         wr(ADR_PA_DIR, 8'h00);
         wait_n(2);
         chk8(port_a_out, 8'h00);
         ovf(1'(1 - s));
         chk8(port_a_out, 8'h00);
         ovf(1'(s));
         chk8(port_a_out, 8'h08);
         op(BIO_OP_CLR, ADR_PA_DATA, 3);
         wait_n(2);
         chk8(port_a_out, 8'h00);
         op(BIO_OP_SET, ADR_PA_DATA, 3);
         ovf(1'(s));
         ovf(1'(s));
         chk8(port_a_out, 8'h08);
         // Pulse option drives bit 0 whatever its direction
         wr(ADR_PA_DIR, 8'h09);
         wait_n(2);
         chk8(port_a_oe, {7'h7b, 1'(s)});
         @(posedge clock);
         pulse_gen_one_output <= 1'b1;
         wait_n(2);
         chk1(port_a_out[0], 1'(s));
         pulse_gen_one_output <= 1'b0;
      end
      wr(ADR_PC_DIR, 8'h00);
      end_sim();
   end
endmodule : tb
